// ### rtl/bst_tap.sv
// Behaviour
// - Standard TAP: state machine, instruction and data registers on four pins.
// - TMS and TDI are sampled on every rising test clock edge.
// - TDO changes on the falling test clock edge only.
// - Pads reach the test logic only while the select pin is high.
// - Codes 0 to 8 decode to the nine listed instructions in order.
// - Four-bit instruction; codes 9 to 15 pick the one-bit bypass.
// - Identification instruction shifts out the fixed device identification word.
// - Each digital pin has a boundary cell; analog pins have none.
module bst_tap #(
   parameter int NUM_CELLS = 8,
   parameter int INSTR_W = 8,
   // Arbitrary identification value, bit 0 set as customary
   parameter logic [31:0] ID_VALUE = 32'h0ABC_D001
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic tck,
   input wire logic scan_function_select_pin,
   input wire bst_pkg::bst_pad_t pad_in,
   input wire logic [NUM_CELLS-1:0] sys_pin_in,
   output logic tdo_reg,
   output logic tdo_oe_reg,
   output bst_pkg::bst_pad_t gpio_in_reg,
   output logic test_active_reg,
   output bst_pkg::bst_mode_t mode_reg,
   output logic [NUM_CELLS-1:0] bsr_out,
   output logic [INSTR_W-1:0] instr_data_reg
);

   ////////////////////////////////////////////////////////////////////////////
   // System clock side: pads as general-purpose inputs
   logic [4:0] clk_sync;

   bst_sync #(.WIDTH(5)) u_clk_sync (
      .clk(clk),
      .resetn(resetn),
      .din({scan_function_select_pin, pad_in}),
      .dout(clk_sync)
   );

   wire logic sel_clk = clk_sync[4];
   wire bst_pkg::bst_pad_t pads_clk = clk_sync[3:0];

   // Pads hidden from the core while test port owns them
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         gpio_in_reg <= '0;
         test_active_reg <= 1'b0;
      end
      else
      begin
         gpio_in_reg <= sel_clk ? '0 : pads_clk;
         test_active_reg <= sel_clk;
      end
   end

   gpio_gate_a: assert property (
      @(posedge clk) disable iff (!resetn) sel_clk |=> gpio_in_reg == '0)
      else $error("pad value leaked to core in test mode");

   ////////////////////////////////////////////////////////////////////////////
   // Test clock side: reset release and select synchronisers
   logic tck_rstn;
   logic tap_en;

   bst_sync #(.WIDTH(1)) u_tck_rst (
      .clk(tck),
      .resetn(resetn),
      .din(1'b1),
      .dout(tck_rstn)
   );

   bst_sync #(.WIDTH(1)) u_tck_sel (
      .clk(tck),
      .resetn(resetn),
      .din(scan_function_select_pin),
      .dout(tap_en)
   );

   // Test inputs gated by the select pin
   wire logic tms_in = tap_en & pad_in.tms;
   wire logic tdi_in = tap_en & pad_in.tdi;

   ////////////////////////////////////////////////////////////////////////////
   // TAP state machine
   bst_pkg::bst_tap_state_t state_reg;
   bst_pkg::bst_tap_state_t state_next;

   // Standard transitions on TMS
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         bst_pkg::TLR: state_next = tms_in ? bst_pkg::TLR : bst_pkg::RTI;
         bst_pkg::RTI: state_next = tms_in ? bst_pkg::SEL_DR : bst_pkg::RTI;
         bst_pkg::SEL_DR: state_next = tms_in ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
         bst_pkg::CAP_DR: state_next = tms_in ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
         bst_pkg::SHIFT_DR: state_next = tms_in ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
         bst_pkg::EXIT1_DR: state_next = tms_in ? bst_pkg::UPD_DR : bst_pkg::PAUSE_DR;
         bst_pkg::PAUSE_DR: state_next = tms_in ? bst_pkg::EXIT2_DR : bst_pkg::PAUSE_DR;
         bst_pkg::EXIT2_DR: state_next = tms_in ? bst_pkg::UPD_DR : bst_pkg::SHIFT_DR;
         bst_pkg::UPD_DR: state_next = tms_in ? bst_pkg::SEL_DR : bst_pkg::RTI;
         bst_pkg::SEL_IR: state_next = tms_in ? bst_pkg::TLR : bst_pkg::CAP_IR;
         bst_pkg::CAP_IR: state_next = tms_in ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
         bst_pkg::SHIFT_IR: state_next = tms_in ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
         bst_pkg::EXIT1_IR: state_next = tms_in ? bst_pkg::UPD_IR : bst_pkg::PAUSE_IR;
         bst_pkg::PAUSE_IR: state_next = tms_in ? bst_pkg::EXIT2_IR : bst_pkg::PAUSE_IR;
         bst_pkg::EXIT2_IR: state_next = tms_in ? bst_pkg::UPD_IR : bst_pkg::SHIFT_IR;
         bst_pkg::UPD_IR: state_next = tms_in ? bst_pkg::SEL_DR : bst_pkg::RTI;
         default: state_next = bst_pkg::TLR;
      endcase
   end

   // State advances on rising test clock; held in reset while deselected
   always_ff @(posedge tck or negedge tck_rstn)
   begin
      if (!tck_rstn)
         state_reg <= bst_pkg::TLR;
      else if (!tap_en)
         state_reg <= bst_pkg::TLR;
      else
         state_reg <= state_next;
   end

   // State decodes
   wire logic in_tlr = (state_reg == bst_pkg::TLR);
   wire logic cap_ir = (state_reg == bst_pkg::CAP_IR);
   wire logic shift_ir = (state_reg == bst_pkg::SHIFT_IR);
   wire logic upd_ir = (state_reg == bst_pkg::UPD_IR);
   wire logic cap_dr = (state_reg == bst_pkg::CAP_DR);
   wire logic shift_dr = (state_reg == bst_pkg::SHIFT_DR);
   wire logic upd_dr = (state_reg == bst_pkg::UPD_DR);
   wire logic in_shift = shift_ir | shift_dr;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction register
   logic [bst_pkg::IR_W-1:0] ir_shift_reg;
   logic [bst_pkg::IR_W-1:0] ir_reg;

   // Capture pattern, shift, update; reset selects identification
   always_ff @(posedge tck or negedge tck_rstn)
   begin
      if (!tck_rstn)
      begin
         ir_shift_reg <= bst_pkg::IR_CAPTURE_VAL;
         ir_reg <= bst_pkg::IR_RESET_VAL;
         mode_reg <= '0;
      end
      else
      begin
         if (cap_ir)
            ir_shift_reg <= bst_pkg::IR_CAPTURE_VAL;
         else if (shift_ir)
            ir_shift_reg <= {tdi_in, ir_shift_reg[bst_pkg::IR_W-1:1]};
         if (in_tlr)
         begin
            ir_reg <= bst_pkg::IR_RESET_VAL;
            mode_reg <= '0;
         end
         else if (upd_ir)
         begin
            ir_reg <= ir_shift_reg;
            mode_reg <= bst_pkg::bst_mode_of(ir_shift_reg);
         end
      end
   end

   // Data register selected by the current instruction
   wire bst_pkg::bst_dr_t dr_sel = bst_pkg::bst_dr_of(ir_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Data registers
   logic bypass_reg;
   logic [bst_pkg::ID_W-1:0] id_shift_reg;
   logic [INSTR_W-1:0] instr_shift_reg;
   logic bsr_so;
   logic [NUM_CELLS-1:0] pins_tck;

   wire logic sel_byp = (dr_sel == bst_pkg::DR_BYPASS);
   wire logic sel_id = (dr_sel == bst_pkg::DR_IDENT);
   wire logic sel_ins = (dr_sel == bst_pkg::DR_INSTR);
   wire logic sel_bsr = (dr_sel == bst_pkg::DR_BSR);

   // Bypass, identification and instrument registers
   always_ff @(posedge tck or negedge tck_rstn)
   begin
      if (!tck_rstn)
      begin
         bypass_reg <= bst_pkg::BYPASS_CAPTURE_VAL;
         id_shift_reg <= ID_VALUE;
         instr_shift_reg <= '0;
         instr_data_reg <= '0;
      end
      else
      begin
         if (cap_dr && sel_byp)
            bypass_reg <= bst_pkg::BYPASS_CAPTURE_VAL;
         else if (shift_dr && sel_byp)
            bypass_reg <= tdi_in;
         if (cap_dr && sel_id)
            id_shift_reg <= ID_VALUE;
         else if (shift_dr && sel_id)
            id_shift_reg <= {tdi_in, id_shift_reg[bst_pkg::ID_W-1:1]};
         if (cap_dr && sel_ins)
            instr_shift_reg <= instr_data_reg;
         else if (shift_dr && sel_ins)
            instr_shift_reg <= {tdi_in, instr_shift_reg[INSTR_W-1:1]};
         if (upd_dr && sel_ins)
            instr_data_reg <= instr_shift_reg;
      end
   end

   // Digital pins only; analog pins are never wired to this bus
   bst_sync #(.WIDTH(NUM_CELLS)) u_pin_sync (
      .clk(tck),
      .resetn(tck_rstn),
      .din(sys_pin_in),
      .dout(pins_tck)
   );

   bst_bsr #(.NUM_CELLS(NUM_CELLS)) u_bsr (
      .tck(tck),
      .rstn(tck_rstn),
      .capture(cap_dr && sel_bsr),
      .shift(shift_dr && sel_bsr),
      .update(upd_dr && sel_bsr),
      .tdi(tdi_in),
      .pin_in(pins_tck),
      .so(bsr_so),
      .upd_reg(bsr_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Serial output on falling test clock
   wire logic dr_so = sel_id ? id_shift_reg[0] :
                      sel_ins ? instr_shift_reg[0] :
                      sel_bsr ? bsr_so : bypass_reg;
   wire logic so_mux = shift_ir ? ir_shift_reg[0] : dr_so;

   always_ff @(negedge tck or negedge tck_rstn)
   begin
      if (!tck_rstn)
      begin
         tdo_reg <= 1'b0;
         tdo_oe_reg <= 1'b0;
      end
      else
      begin
         tdo_reg <= in_shift ? so_mux : 1'b0;
         tdo_oe_reg <= in_shift;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   deselect_reset_a: assert property (
      @(posedge tck) disable iff (!tck_rstn) !tap_en |=> state_reg == bst_pkg::TLR)
      else $error("TAP active while port deselected");

   tms_five_a: assert property (
      @(posedge tck) disable iff (!tck_rstn) tms_in [*5] |-> ##1 state_reg == bst_pkg::TLR)
      else $error("five TMS ones did not reach reset");

   tdo_enable_a: assert property (
      @(posedge tck) disable iff (!tck_rstn) ##1 tdo_oe_reg == in_shift)
      else $error("TDO enable outside shift states");

   bypass_path_a: assert property (
      @(posedge tck) disable iff (!tck_rstn)
      (shift_dr && sel_byp && $past(shift_dr)) |-> tdo_reg == $past(tdi_in))
      else $error("bypass is not one stage TDI to TDO");

   tdo_falling_a: assert property (
      @(posedge tck) disable iff (!tck_rstn) ##1 in_shift |-> tdo_reg == so_mux)
      else $error("TDO not updated on falling edge");

   ir_capture_a: assert property (
      @(posedge tck) disable iff (!tck_rstn) cap_ir |=> ir_shift_reg == bst_pkg::IR_CAPTURE_VAL)
      else $error("instruction capture pattern wrong");

   ir_update_a: assert property (
      @(posedge tck) disable iff (!tck_rstn)
      upd_ir |=> ir_reg == $past(ir_shift_reg) && mode_reg == bst_pkg::bst_mode_of($past(ir_shift_reg)))
      else $error("instruction update or decode wrong");

   ident_reset_a: assert property (
      @(posedge tck) disable iff (!tck_rstn) in_tlr |=> ir_reg == bst_pkg::IR_IDENTIFICATION_INSTRUCTION)
      else $error("reset did not select identification");

   ident_capture_a: assert property (
      @(posedge tck) disable iff (!tck_rstn) (cap_dr && sel_id) |=> id_shift_reg == ID_VALUE)
      else $error("identification word not captured");

   ident_shift_c: cover property (@(posedge tck) disable iff (!tck_rstn) shift_dr && sel_id);
   extest_load_c: cover property (@(posedge tck) disable iff (!tck_rstn) upd_ir ##1 mode_reg.drive_bsr);
   bypass_shift_c: cover property (@(posedge tck) disable iff (!tck_rstn) shift_dr && sel_byp [*3]);
   bsr_update_c: cover property (@(posedge tck) disable iff (!tck_rstn) upd_dr && sel_bsr);

endmodule : bst_tap

// ### inc/bst_pkg.sv
package bst_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction register
   localparam int IR_W = 4;
   localparam logic [3:0] IR_CLAMP = 4'h0;
   localparam logic [3:0] IR_EXTEST = 4'h1;
   localparam logic [3:0] IR_EXTEST_PULSE = 4'h2;
   localparam logic [3:0] IR_EXTEST_TRAIN = 4'h3;
   localparam logic [3:0] IR_INTEST = 4'h4;
   localparam logic [3:0] IR_SAMPLE_PRELOAD = 4'h5;
   localparam logic [3:0] IR_HIGHZ = 4'h6;
   localparam logic [3:0] IR_EMBEDDED_INSTRUMENT_ACCESS = 4'h7;
   localparam logic [3:0] IR_IDENTIFICATION_INSTRUCTION = 4'h8;
   localparam logic [3:0] IR_BYPASS_FIRST = 4'h9;
   // Fixed pattern loaded in capture-IR, low bits 01 as customary
   localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;
   // Instruction after test logic reset
   localparam logic [3:0] IR_RESET_VAL = IR_IDENTIFICATION_INSTRUCTION;
   localparam int ID_W = 32;
   localparam logic BYPASS_CAPTURE_VAL = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
      SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
   } bst_tap_state_t;

   typedef enum logic [1:0] {DR_BYPASS, DR_BSR, DR_IDENT, DR_INSTR} bst_dr_t;

   typedef struct packed {
      logic drive_bsr;
      logic force_highz;
      logic intest;
      logic ac_pulse;
      logic ac_train;
   } bst_mode_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic tdo;
   } bst_pad_t;

   ////////////////////////////////////////////////////////////////////////////
   // Data register chosen by an instruction
   function automatic bst_dr_t bst_dr_of(input logic [3:0] ir);
      bst_dr_t r;
      r = DR_BYPASS;
      if (ir == IR_EXTEST || ir == IR_EXTEST_PULSE || ir == IR_EXTEST_TRAIN ||
          ir == IR_INTEST || ir == IR_SAMPLE_PRELOAD)
         r = DR_BSR;
      else if (ir == IR_EMBEDDED_INSTRUMENT_ACCESS)
         r = DR_INSTR;
      else if (ir == IR_IDENTIFICATION_INSTRUCTION)
         r = DR_IDENT;
      return r;
   endfunction : bst_dr_of

   // Pin control implied by an instruction
   function automatic bst_mode_t bst_mode_of(input logic [3:0] ir);
      bst_mode_t m;
      m = '0;
      m.drive_bsr = (ir <= IR_EXTEST_TRAIN);
      m.force_highz = (ir == IR_HIGHZ);
      m.intest = (ir == IR_INTEST);
      m.ac_pulse = (ir == IR_EXTEST_PULSE);
      m.ac_train = (ir == IR_EXTEST_TRAIN);
      return m;
   endfunction : bst_mode_of

endpackage : bst_pkg

// ### rtl/bst_sync.sv
// Two-flop synchroniser, async active-low reset to zero
module bst_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_reg;

   // First stage is read only by the second
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_reg <= '0;
         dout <= '0;
      end
      else
      begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end

endmodule : bst_sync

// ### rtl/bst_bsr.sv
// Boundary register: one cell per digital pin
module bst_bsr #(
   parameter int NUM_CELLS = 8
) (
   input wire logic tck,
   input wire logic rstn,
   input wire logic capture,
   input wire logic shift,
   input wire logic update,
   input wire logic tdi,
   input wire logic [NUM_CELLS-1:0] pin_in,
   output logic so,
   output logic [NUM_CELLS-1:0] upd_reg
);

   logic [NUM_CELLS-1:0] chain_reg;

   assign so = chain_reg[0];

   // Capture, shift toward bit 0, update latch
   always_ff @(posedge tck or negedge rstn)
   begin
      if (!rstn)
      begin
         chain_reg <= '0;
         upd_reg <= '0;
      end
      else
      begin
         if (capture)
            chain_reg <= pin_in;
         else if (shift)
            chain_reg <= {tdi, chain_reg[NUM_CELLS-1:1]};
         if (update)
            upd_reg <= chain_reg;
      end
   end

   cell_capture_a: assert property (
      @(posedge tck) disable iff (!rstn) capture |=> chain_reg == $past(pin_in))
      else $error("boundary cells missed pin capture");

endmodule : bst_bsr

// ### verification/bst_tester.sv
////////////////////////////////////////////////////////////////////////////////
// Board tester on the far side of the test port
module bst_tester (
   output logic tck,
   output logic tms,
   output logic tdi
);
   timeunit 1ns;
   timeprecision 100ps;

   // Test clock stands low between frames
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One test clock period; mode and data change at the falling edge
   task automatic step(input logic m, input logic d);
      tms <= m;
      tdi <= d;
      #32 tck = 1'b1;
      #32 tck = 1'b0;
   endtask : step

   // Walk of mode bits, first bit first, data low
   task automatic walk(input logic [7:0] seq, input int n);
      for (int i = 0; i < n; i++)
         step(seq[i], 1'b0);
   endtask : walk

   // Six mode ones to Test-Logic-Reset, then Run-Test/Idle
   task automatic reset_tap();
      walk(8'h3F, 7);
   endtask : reset_tap

   // From Run-Test/Idle through capture and shift, LSB first, then update and idle
   task automatic shift(input logic ir, input logic [63:0] data, input int n);
      if (ir)
         walk(8'h03, 4);
      else
         walk(8'h01, 3);
      for (int i = 0; i < n; i++)
         step(i == n - 1, data[i]);
      walk(8'h01, 2);
   endtask : shift

endmodule : bst_tester

// ### verification/test_boundary_scan_tap.sv
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench of the boundary-scan port
module test_boundary_scan_tap;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int NC = 8;
   localparam int IW = 8;
   // Arbitrary identification value
   localparam logic [31:0] ID_VAL = 32'h5A3C_0F69;

   logic clk;
   logic resetn;
   logic sel;
   logic [NC-1:0] pins;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;
   logic last_tdo = 1'b0;
   logic tdo_wire;
   logic test_active;
   logic [NC-1:0] bsr_out;
   logic [IW-1:0] instr;
   logic [IW-1:0] exp_instr;
   bst_pkg::bst_pad_t gp_pad;
   bst_pkg::bst_pad_t pad;
   bst_pkg::bst_pad_t gpio_in;
   bst_pkg::bst_mode_t mode;
   int err_count;
   int n_compared;
   logic exp_q[$];

   ////////////////////////////////////////////////////////////////////////////
   // Released output pad shows the inverse of its last driven level
   assign tdo_wire = tdo_oe ? tdo : ~last_tdo;
   assign pad = sel ? {tck, tms, tdi, tdo_wire} : gp_pad;

   bst_tap #(.NUM_CELLS(NC), .INSTR_W(IW), .ID_VALUE(ID_VAL)) DUT (
      .clk(clk), .resetn(resetn), .tck(tck), .scan_function_select_pin(sel), .pad_in(pad),
      .sys_pin_in(pins), .tdo_reg(tdo), .tdo_oe_reg(tdo_oe), .gpio_in_reg(gpio_in),
      .test_active_reg(test_active), .mode_reg(mode), .bsr_out(bsr_out), .instr_data_reg(instr));

   bst_tester tst (.tck(tck), .tms(tms), .tdi(tdi));

   // System clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   // Verdict and end of run
   task automatic finish_test();
      if (err_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   function automatic logic [63:0] rnd();
      return {$urandom(), $urandom()};
   endfunction : rnd

   // Notes twice the length: captured word first, then the bits shifted in
   task automatic run(input logic ir, input int len, input logic [63:0] cap, input logic [63:0] din);
      for (int i = 0; i < 2 * len; i++)
         exp_q.push_back(i < len ? cap[i] : din[i - len]);
      tst.shift(ir, din, 2 * len);
      check(exp_q.size(), 0);
   endtask : run

   ////////////////////////////////////////////////////////////////////////////
   // Takes the oldest note whenever the port drives a result
   always @(posedge tck)
   begin
      if (tdo_oe === 1'b1)
      begin
         last_tdo <= tdo;
         check(exp_q.size() > 0, 1'b1);
         if (exp_q.size() > 0)
            check(tdo_wire, exp_q.pop_front());
      end
   end

   // Hang guard
   initial
   begin
      repeat (60000) @(posedge clk);
      err_count++;
      finish_test();
   end

   // Main sequence
   initial
   begin
      logic [63:0] d;
      logic [63:0] cap;
      logic [3:0] c;
      int len;
      resetn = 1'b0;
      sel = 1'b0;
      gp_pad = '0;
      pins = '0;
      exp_instr = '0;
      err_count = 0;
      n_compared = 0;
      void'($urandom(36));
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      // Pads belong to the core while the select pin is low
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk);
         gp_pad <= 4'($urandom());
         pins <= NC'($urandom());
         repeat (4) @(posedge clk);
         check(gpio_in, gp_pad);
         check(test_active, 1'b0);
      end
      @(posedge clk);
      sel <= 1'b1;
      repeat (4) @(posedge clk);
      check(test_active, 1'b1);
      check(gpio_in, 4'h0);
      // Keep test clock edges off the system clock edges
      #1.3;
      tst.reset_tap();
      run(1'b0, 32, ID_VAL, rnd());
      // Every instruction code, then its data register
      for (int k = 0; k < 16; k++)
      begin
         c = k[3:0];
         run(1'b1, 4, bst_pkg::IR_CAPTURE_VAL, {56'h0, c, 4'($urandom())});
         check(mode, {c <= 4'h3, c == 4'h6, c == 4'h4, c == 4'h2, c == 4'h3});
         len = 1;
         cap = '0;
         if (c == bst_pkg::IR_IDENTIFICATION_INSTRUCTION)
         begin
            len = 32;
            cap = 64'(ID_VAL);
         end
         else if (c >= 4'h1 && c <= 4'h5)
         begin
            len = NC;
            cap = 64'(pins);
         end
         else if (c == 4'h7)
         begin
            len = IW;
            cap = 64'(exp_instr);
         end
         d = rnd();
         run(1'b0, len, cap, d);
         if (c >= 4'h1 && c <= 4'h5)
            check(bsr_out, d[2 * NC - 1:NC]);
         if (c == 4'h7)
            exp_instr = d[2 * IW - 1:IW];
         check(instr, exp_instr);
      end
      // Test-Logic-Reset clears pin control and restores identification
      tst.reset_tap();
      check(mode, 5'h00);
      run(1'b0, 32, ID_VAL, rnd());
      // Deselect mid-run: pads return to the core, TAP falls to reset
      run(1'b1, 4, bst_pkg::IR_CAPTURE_VAL, {56'h0, bst_pkg::IR_EXTEST, 4'($urandom())});
      check(mode, 5'h10);
      @(posedge clk);
      sel <= 1'b0;
      gp_pad <= 4'h4;
      repeat (4) @(posedge clk);
      check(gpio_in, 4'h4);
      check(test_active, 1'b0);
      #1.3;
      tst.walk(8'h00, 4);
      check(mode, 5'h00);
      @(posedge clk);
      sel <= 1'b1;
      repeat (4) @(posedge clk);
      check(test_active, 1'b1);
      #1.3;
      tst.reset_tap();
      run(1'b0, 32, ID_VAL, rnd());
      finish_test();
   end

endmodule : test_boundary_scan_tap
